// File: verilog/mpcs_pkg.sv
// Package for the media pipe command sequencer: command codes, thread
// layout constants, bus map and carrier structs.
// Assumes a single 100 MHz clock domain and a classic Wishbone master.
package mpcs_pkg;

   // ****************************************************************
   // Command codes seen on the command stream
   // ****************************************************************
   typedef enum logic [3:0] {
      MPCS_CMD_FLUSH      = 4'b0000,
      MPCS_CMD_PIPE_CTRL  = 4'b0001,
      MPCS_CMD_REG_LOAD   = 4'b0010,
      MPCS_CMD_SETUP      = 4'b0011,
      MPCS_CMD_PIPE_SEL   = 4'b0100,
      MPCS_CMD_FENCE      = 4'b0101,
      MPCS_CMD_BASE_ADDR  = 4'b0110,
      MPCS_CMD_STATE_PTR  = 4'b0111,
      MPCS_CMD_CS_BUF     = 4'b1000,
      MPCS_CMD_PREFETCH   = 4'b1001,
      MPCS_CMD_SYS_RTN    = 4'b1010,
      MPCS_CMD_CONST_BUF  = 4'b1011,
      MPCS_CMD_PRIMITIVE  = 4'b1100
   } mpcs_cmd_t;

   // Sequence step reached so far
   typedef enum logic [2:0] {
      MPCS_ST_IDLE   = 3'b000,
      MPCS_ST_FLUSH  = 3'b001,
      MPCS_ST_SEL    = 3'b010,
      MPCS_ST_FENCE  = 3'b011,
      MPCS_ST_STATE  = 3'b100,
      MPCS_ST_CONST  = 3'b101,
      MPCS_ST_PRIM   = 3'b110
   } mpcs_step_t;

   // One command from the streamer
   typedef struct packed {
      mpcs_cmd_t   op;
      logic [31:0] arg0;
      logic [31:0] arg1;
   } mpcs_cmd_word_t;

   // Root or child thread request to the thread dispatcher
   typedef struct packed {
      logic        child;
      logic        has_ret;
      logic [15:0] ret_handle;
      logic        const_en;
      logic [15:0] const_handle;
      logic [1:0]  const_slot;
      logic [15:0] tail_handle;
   } mpcs_thread_t;

   // Return buffer write (write-only port)
   typedef struct packed {
      logic [15:0] handle;
      logic [31:0] data;
   } mpcs_rbuf_wr_t;

   localparam int unsigned MPCS_HDL_W = 16;
   localparam logic [1:0] MPCS_SLOT_AFTER_HDR = 2'h1;
   localparam logic [1:0] MPCS_SLOT_NONE = 2'h0;
   localparam logic [15:0] MPCS_HDL_STEP = 16'h0001;
   localparam logic [7:0] MPCS_SPAWNER_SFID = 8'h07;
   localparam logic [31:0] MPCS_VC_DIS_DATA = 32'h1000_0000;
   localparam logic [31:0] MPCS_VC_EN_DATA = 32'h1000_1000;
   localparam logic [31:0] MPCS_VC_REG_OFS = 32'h0000_2124;
   localparam int unsigned MPCS_VC_BIT = 15;

   // ****************************************************************
   // Register map (word aligned byte offsets)
   // ****************************************************************
   localparam logic [7:0] MPCS_A_CTRL = 8'h00;
   localparam logic [7:0] MPCS_A_STATUS = 8'h04;
   localparam logic [7:0] MPCS_A_OBJ_BASE = 8'h08;
   localparam logic [7:0] MPCS_A_OBJ_BOUND = 8'h0C;
   localparam logic [7:0] MPCS_A_ERR_CNT = 8'h10;
   localparam logic [7:0] MPCS_A_TERM_CNT = 8'h14;
   localparam logic [31:0] MPCS_CTRL_RST = 32'h0000_0001;
   localparam int unsigned MPCS_CTRL_CHK_EN = 0;
   localparam int unsigned MPCS_CTRL_ERR_CLR = 1;

endpackage

// File: verilog/mpcs_top.sv
// Media pipe command sequencer: front-end unit, thread spawner hooks,
// indirect-object window and a command order checker with Wishbone regs.
// Assumes commands arrive one per valid cycle, synchronous to clk_i.
`timescale 1ns/1ps

// Operation
// - Front end only writes return buffer; spawner has no buffer connection.
// - With constant buffer enabled, front end forwards its handle to spawner.
// - A root thread carries at most one return-buffer handle.
// - Payload handle allocated by front end doubles as thread return handle.
// - Root thread constant data lands right after header register.
// - Child thread: split parent handles, insert constants after header register.
// - Spawner takes messages for its own id, never snoops output bus.
// - Base address required first among state; last one wins.
// - Indirect object base and bound govern indirect fetch address.
module mpcs_top
   import mpcs_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Command stream
   input wire logic cmd_valid_i,
   input wire mpcs_pkg::mpcs_cmd_word_t cmd_i,
   // Thread requests (root from front end, child from execution units)
   input wire logic child_req_i,
   input wire logic [15:0] child_hdl_a_i,
   input wire logic [15:0] child_hdl_b_i,
   output mpcs_pkg::mpcs_thread_t thread_o,
   output logic thread_valid_o,
   // Return buffer write port and indirect fetch address
   output mpcs_pkg::mpcs_rbuf_wr_t rbuf_wr_o,
   output logic rbuf_wr_valid_o,
   output logic [31:0] obj_fetch_addr_o,
   output logic obj_fetch_ok_o,
   // Message bus to spawner
   input wire logic msg_valid_i,
   input wire logic [7:0] msg_sfid_i,
   input wire logic msg_term_i,
   // Sequence error flag
   output logic seq_err_o
);
   import mpcs_pkg::*;

   // ****************************************************************
   // Sequence checker
   // ****************************************************************
   mpcs_step_t step_q, step_d;
   logic err_q, err_d;
   logic sel_seen_q, sel_seen_d;
   logic fence_seen_q, fence_seen_d;
   logic base_seen_q, base_seen_d;
   logic [7:0] err_cnt_q, err_cnt_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic wr_ctrl;

   function automatic mpcs_step_t cmd_step(input mpcs_cmd_t op);
      case (op)
         MPCS_CMD_FLUSH, MPCS_CMD_PIPE_CTRL, MPCS_CMD_REG_LOAD: cmd_step = MPCS_ST_FLUSH;
         MPCS_CMD_SETUP, MPCS_CMD_PIPE_SEL: cmd_step = MPCS_ST_SEL;
         MPCS_CMD_FENCE: cmd_step = MPCS_ST_FENCE;
         MPCS_CMD_CONST_BUF: cmd_step = MPCS_ST_CONST;
         MPCS_CMD_PRIMITIVE: cmd_step = MPCS_ST_PRIM;
         default: cmd_step = MPCS_ST_STATE;
      endcase
   endfunction

   function automatic logic is_flush(input mpcs_cmd_t op);
      is_flush = (op == MPCS_CMD_FLUSH) || (op == MPCS_CMD_PIPE_CTRL);
   endfunction

   // Step tracking; base address may float before earlier steps
   always_comb
   begin
      logic bad;
      mpcs_step_t s;
      bad = 1'b0;
      s = cmd_step(cmd_i.op);
      step_d = step_q;
      sel_seen_d = sel_seen_q;
      fence_seen_d = fence_seen_q;
      base_seen_d = base_seen_q;
      if (cmd_valid_i)
      begin
         if (is_flush(cmd_i.op))
         begin
            step_d = MPCS_ST_FLUSH;
            base_seen_d = base_seen_q;
         end
         else if (cmd_i.op == MPCS_CMD_BASE_ADDR)
         begin
            base_seen_d = 1'b1;
            if (step_q == MPCS_ST_PRIM || step_q == MPCS_ST_CONST || step_q == MPCS_ST_IDLE)
               bad = 1'b1;
         end
         else
         begin
            // Going back to an earlier step, or skipping the flush, is an error
            if (step_q == MPCS_ST_IDLE || s < step_q)
               bad = 1'b1;
            if (s == MPCS_ST_STATE && !base_seen_q)
               bad = 1'b1;
            if (cmd_i.op == MPCS_CMD_PIPE_SEL && !sel_seen_q && (!fence_seen_q || !base_seen_q))
               bad = 1'b1;
            if (cmd_i.op == MPCS_CMD_FENCE && step_q == MPCS_ST_FENCE)
               bad = 1'b1;
            if (cmd_i.op == MPCS_CMD_CONST_BUF && step_q == MPCS_ST_CONST)
               bad = 1'b1;
            if (s != MPCS_ST_FENCE && step_q == MPCS_ST_SEL && cmd_i.op != MPCS_CMD_PIPE_SEL
                && cmd_i.op != MPCS_CMD_SETUP)
               bad = 1'b1;
            if (cmd_i.op == MPCS_CMD_CS_BUF && cmd_i.arg0 != 32'h0000_0001
                && cmd_i.arg0 != 32'h0000_0000)
               bad = 1'b1;
            if (cmd_i.op == MPCS_CMD_PIPE_SEL)
               sel_seen_d = 1'b1;
            if (cmd_i.op == MPCS_CMD_FENCE)
               fence_seen_d = 1'b1;
            if (!bad)
               step_d = s;
         end
      end
      bad = bad & ctrl_q[MPCS_CTRL_CHK_EN];
      // A new error wins over a software clear in the same cycle
      err_d = bad | (err_q & ~(wr_ctrl & wb_dat_i[MPCS_CTRL_ERR_CLR]));
      err_cnt_d = err_cnt_q + {7'h00, bad};
   end

   // ****************************************************************
   // Front end: handles, constant buffer, return-buffer writes
   // ****************************************************************
   logic [15:0] hdl_next_q, hdl_next_d;
   logic [15:0] const_hdl_q, const_hdl_d;
   logic const_en_q, const_en_d;
   logic [31:0] obj_base_q, obj_base_d, obj_bound_q, obj_bound_d;
   mpcs_thread_t thr_q, thr_d;
   logic thr_v_q, thr_v_d;
   mpcs_rbuf_wr_t rbw_q, rbw_d;
   logic rbw_v_q, rbw_v_d;
   logic [31:0] fetch_q, fetch_d;
   logic fetch_ok_q, fetch_ok_d;
   logic [15:0] term_cnt_q, term_cnt_d;

   always_comb
   begin
      hdl_next_d = hdl_next_q;
      const_hdl_d = const_hdl_q;
      const_en_d = const_en_q;
      obj_base_d = obj_base_q;
      obj_bound_d = obj_bound_q;
      thr_d = thr_q;
      thr_v_d = 1'b0;
      rbw_d = rbw_q;
      rbw_v_d = 1'b0;
      fetch_d = fetch_q;
      fetch_ok_d = fetch_ok_q;
      term_cnt_d = term_cnt_q;
      if (cmd_valid_i && cmd_i.op == MPCS_CMD_CONST_BUF)
      begin
         const_en_d = cmd_i.arg0[0];
         const_hdl_d = cmd_i.arg1[15:0];
      end
      if (cmd_valid_i && cmd_i.op == MPCS_CMD_BASE_ADDR)
      begin
         obj_base_d = cmd_i.arg0; // last one wins
         obj_bound_d = cmd_i.arg1;
      end
      if (child_req_i)
      begin
         // Child: split parent handles and slot constants after header
         thr_d.child = 1'b1;
         thr_d.has_ret = 1'b0;
         thr_d.ret_handle = child_hdl_a_i;
         thr_d.tail_handle = child_hdl_b_i;
         thr_d.const_en = const_en_q;
         thr_d.const_handle = const_hdl_q;
         thr_d.const_slot = const_en_q ? MPCS_SLOT_AFTER_HDR : MPCS_SLOT_NONE;
         thr_v_d = 1'b1;
      end
      else if (cmd_valid_i && cmd_i.op == MPCS_CMD_PRIMITIVE)
      begin
         // Root: one handle, serving as payload and return handle
         thr_d.child = 1'b0;
         thr_d.has_ret = 1'b1;
         thr_d.ret_handle = hdl_next_q;
         thr_d.tail_handle = hdl_next_q;
         thr_d.const_en = const_en_q;
         thr_d.const_handle = const_hdl_q;
         thr_d.const_slot = const_en_q ? MPCS_SLOT_AFTER_HDR : MPCS_SLOT_NONE;
         thr_v_d = 1'b1;
         rbw_d.handle = hdl_next_q; // write only, no read path
         rbw_d.data = cmd_i.arg0;
         rbw_v_d = 1'b1;
         hdl_next_d = hdl_next_q + MPCS_HDL_STEP;
         fetch_d = obj_base_q + cmd_i.arg1;
         fetch_ok_d = (obj_base_q + cmd_i.arg1) < obj_bound_q;
      end
      // Spawner listens only to its own id; output bus is not observed
      if (msg_valid_i && msg_sfid_i == MPCS_SPAWNER_SFID && msg_term_i)
         term_cnt_d = term_cnt_q + MPCS_HDL_STEP;
   end

   // ****************************************************************
   // Wishbone slave, one-wait-state ack
   // ****************************************************************
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & (wb_adr_i == MPCS_A_CTRL);

   always_comb
   begin
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      ctrl_d = ctrl_q;
      if (wr_ctrl && wb_sel_i[0])
         ctrl_d = {31'h0000_0000, wb_dat_i[MPCS_CTRL_CHK_EN]};
      case (wb_adr_i)
         MPCS_A_CTRL: rdat_d = ctrl_q;
         MPCS_A_STATUS: rdat_d = {25'h000_0000, err_q, 3'h0, step_q};
         MPCS_A_OBJ_BASE: rdat_d = obj_base_q;
         MPCS_A_OBJ_BOUND: rdat_d = obj_bound_q;
         MPCS_A_ERR_CNT: rdat_d = {24'h00_0000, err_cnt_q};
         MPCS_A_TERM_CNT: rdat_d = {16'h0000, term_cnt_q};
         default: rdat_d = 32'h0000_0000;
      endcase
   end

   // All state registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         step_q <= MPCS_ST_IDLE;
         err_q <= 1'b0;
         sel_seen_q <= 1'b0;
         fence_seen_q <= 1'b0;
         base_seen_q <= 1'b0;
         err_cnt_q <= 8'h00;
         ctrl_q <= MPCS_CTRL_RST;
         hdl_next_q <= 16'h0000;
         const_hdl_q <= 16'h0000;
         const_en_q <= 1'b0;
         obj_base_q <= 32'h0000_0000;
         obj_bound_q <= 32'h0000_0000;
         thr_q <= '0;
         thr_v_q <= 1'b0;
         rbw_q <= '0;
         rbw_v_q <= 1'b0;
         fetch_q <= 32'h0000_0000;
         fetch_ok_q <= 1'b0;
         term_cnt_q <= 16'h0000;
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         step_q <= step_d;
         err_q <= err_d;
         sel_seen_q <= sel_seen_d;
         fence_seen_q <= fence_seen_d;
         base_seen_q <= base_seen_d;
         err_cnt_q <= err_cnt_d;
         ctrl_q <= ctrl_d;
         hdl_next_q <= hdl_next_d;
         const_hdl_q <= const_hdl_d;
         const_en_q <= const_en_d;
         obj_base_q <= obj_base_d;
         obj_bound_q <= obj_bound_d;
         thr_q <= thr_d;
         thr_v_q <= thr_v_d;
         rbw_q <= rbw_d;
         rbw_v_q <= rbw_v_d;
         fetch_q <= fetch_d;
         fetch_ok_q <= fetch_ok_d;
         term_cnt_q <= term_cnt_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign thread_o = thr_q;
   assign thread_valid_o = thr_v_q;
   assign rbuf_wr_o = rbw_q;
   assign rbuf_wr_valid_o = rbw_v_q;
   assign obj_fetch_addr_o = fetch_q;
   assign obj_fetch_ok_o = fetch_ok_q;
   assign seq_err_o = err_q;

endmodule

// File: dv/mpcs_streamer_model.sv
// Command streamer model: plays a fixed media setup sequence on request.
// Assumes the bench pulses play_i and holds bad_i through the whole run.
`timescale 1ns/1ps
module mpcs_streamer_model
(
   // Clock, reset and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic play_i,
   input wire logic bad_i,
   // Command stream and status
   output logic cmd_valid_o,
   output mpcs_pkg::mpcs_cmd_word_t cmd_o,
   output logic done_o
);
   import mpcs_pkg::*;
   logic [4:0] idx_q;
   logic [4:0] idx_d;
   logic run_q;
   logic run_d;
   // ************************************************************
   // Command table
   // ************************************************************
   function automatic mpcs_cmd_word_t row(input logic [4:0] i);
      case (i)
         5'd0: row = '{MPCS_CMD_FLUSH, 32'h0, 32'h0};
         5'd1: row = '{MPCS_CMD_REG_LOAD, MPCS_VC_REG_OFS, MPCS_VC_DIS_DATA};
         5'd2: row = '{MPCS_CMD_FLUSH, 32'h0, 32'h0};
         5'd3: row = '{MPCS_CMD_REG_LOAD, MPCS_VC_REG_OFS, MPCS_VC_EN_DATA};
         5'd4: row = '{MPCS_CMD_SETUP, 32'h0, 32'h0}; // Zero setup entries
         5'd5: row = '{MPCS_CMD_FENCE, 32'h0, 32'h0}; // All fences zero
         5'd6: row = '{MPCS_CMD_BASE_ADDR, 32'h0000_1000, 32'h0000_2000};
         5'd7: row = '{MPCS_CMD_FLUSH, 32'h0, 32'h0};
         5'd8: row = '{MPCS_CMD_PIPE_SEL, 32'h0, 32'h0};
         5'd9: row = '{MPCS_CMD_FENCE, 32'h1, 32'h0}; // Streamer gets entries
         5'd10: row = '{MPCS_CMD_BASE_ADDR, 32'h0000_1000, 32'h0000_2000};
         5'd11: row = '{MPCS_CMD_STATE_PTR, 32'h0, 32'h0};
         5'd12: row = '{MPCS_CMD_CS_BUF, 32'h1, 32'h0};
         5'd13: row = '{MPCS_CMD_PREFETCH, 32'h0, 32'h0};
         5'd14: row = '{MPCS_CMD_SYS_RTN, 32'h0, 32'h0};
         5'd15: row = '{MPCS_CMD_CONST_BUF, 32'h1, 32'h0000_00C3};
         5'd16: row = '{MPCS_CMD_PRIMITIVE, 32'h5A5A_0001, 32'h0000_0100};
         5'd17: row = '{MPCS_CMD_STATE_PTR, 32'h0, 32'h0}; // Late state, only on request
         default: row = '0;
      endcase
   endfunction
   // Idle cycles show inverted data so a stale command never looks valid
   assign cmd_valid_o = run_q;
   assign cmd_o = run_q ? row(idx_q) : mpcs_cmd_word_t'(~row(idx_q));
   assign done_o = !run_q;
   // Next step of the run; the bad run adds one command past the end
   always_comb
   begin
      run_d = run_q;
      idx_d = idx_q;
      if (play_i && !run_q)
      begin
         run_d = 1'b1;
         idx_d = 5'd0;
      end
      else if (run_q)
      begin
         idx_d = idx_q + 5'd1;
         run_d = idx_q != (bad_i ? 5'd17 : 5'd16);
      end
   end
   // Run state registers
   always_ff @(posedge clk_i)
   begin
      run_q <= rst_i ? 1'b0 : run_d;
      idx_q <= rst_i ? 5'd0 : idx_d;
   end
endmodule

// File: dv/mpcs_top_assertions.sv
// Port checker for the media pipe command sequencer.
// Assumes one clock and a synchronous active-high reset; bound into mpcs_top.
`timescale 1ns/1ps
module mpcs_assertions
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Commands, threads and messages
   input wire logic cmd_valid_i,
   input wire mpcs_pkg::mpcs_cmd_word_t cmd_i,
   input wire logic child_req_i,
   input wire logic [15:0] child_hdl_a_i,
   input wire logic [15:0] child_hdl_b_i,
   input wire mpcs_pkg::mpcs_thread_t thread_o,
   input wire logic thread_valid_o,
   input wire mpcs_pkg::mpcs_rbuf_wr_t rbuf_wr_o,
   input wire logic rbuf_wr_valid_o,
   input wire logic [31:0] obj_fetch_addr_o,
   input wire logic obj_fetch_ok_o,
   input wire logic msg_valid_i,
   input wire logic [7:0] msg_sfid_i,
   input wire logic msg_term_i,
   input wire logic seq_err_o
);
   import mpcs_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [15:0] cb_hdl_q;
   logic cb_en_q;
   logic prim_q;
   logic [31:0] base_q;
   logic [31:0] bound_q;
   logic prim;
   assign prim = cmd_valid_i && cmd_i.op == MPCS_CMD_PRIMITIVE && !child_req_i;
   // Shadow of streamer state; assumes the check enable stays set
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cb_hdl_q <= 16'h0;
         cb_en_q <= 1'b0;
         prim_q <= 1'b0;
         base_q <= 32'h0;
         bound_q <= 32'h0;
      end
      else if (cmd_valid_i)
      begin
         if (cmd_i.op == MPCS_CMD_CONST_BUF)
         begin
            cb_en_q <= cmd_i.arg0[0];
            cb_hdl_q <= cmd_i.arg1[15:0];
         end
         if (cmd_i.op == MPCS_CMD_BASE_ADDR)
         begin
            base_q <= cmd_i.arg0;
            bound_q <= cmd_i.arg1;
         end
         if (cmd_i.op == MPCS_CMD_PRIMITIVE)
            prim_q <= 1'b1;
         else if (cmd_i.op == MPCS_CMD_FLUSH || cmd_i.op == MPCS_CMD_PIPE_CTRL)
            prim_q <= 1'b0;
      end
   end
   ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held");
   root_thread_a: assert property (
      prim |=> thread_valid_o && !thread_o.child && rbuf_wr_valid_o)
      else $error("no root thread");
   ret_handle_a: assert property (
      thread_valid_o && !thread_o.child && thread_o.has_ret
      |-> rbuf_wr_valid_o && thread_o.ret_handle == rbuf_wr_o.handle)
      else $error("return handle differs");
   const_handle_a: assert property (
      thread_valid_o && !thread_o.child && cb_en_q
      |-> thread_o.const_en && thread_o.const_handle == cb_hdl_q)
      else $error("constant handle wrong");
   const_slot_a: assert property (
      thread_valid_o && thread_o.const_en |-> thread_o.const_slot == MPCS_SLOT_AFTER_HDR)
      else $error("constant slot wrong");
   child_thread_a: assert property (child_req_i |=> thread_valid_o && thread_o.child)
      else $error("no child thread");
   fetch_window_a: assert property (
      prim |=> obj_fetch_addr_o == base_q + $past(cmd_i.arg1)
      && obj_fetch_ok_o == (obj_fetch_addr_o < bound_q))
      else $error("fetch address wrong");
   late_state_a: assert property (
      cmd_valid_i && prim_q && cmd_i.op >= MPCS_CMD_SETUP
      && cmd_i.op <= MPCS_CMD_CONST_BUF |=> seq_err_o)
      else $error("late state not flagged");
   err_sticky_a: assert property (
      seq_err_o && !wb_we_i && !$past(wb_we_i) |=> seq_err_o)
      else $error("error flag dropped");
endmodule

bind mpcs_top mpcs_assertions chk (.*);

// File: dv/mpcs_top_tb.sv
// Self-checking bench for the media pipe command sequencer.
// Assumes the streamer model feeds commands; the bench owns bus and pulses.
`timescale 1ns/1ps
module mpcs_top_tb;
   import mpcs_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] e; string n;} mpcs_row_t;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_valid_i;
   logic child_req_i, thread_valid_o, rbuf_wr_valid_o, obj_fetch_ok_o;
   logic msg_valid_i, msg_term_i, seq_err_o, play, bad, done;
   logic [7:0] wb_adr_i, msg_sfid_i;
   logic [3:0] wb_sel_i;
   logic [15:0] child_hdl_a_i, child_hdl_b_i;
   logic [31:0] wb_dat_i, wb_dat_o, obj_fetch_addr_o, rd;
   mpcs_cmd_word_t cmd_i;
   mpcs_thread_t thread_o, th;
   mpcs_rbuf_wr_t rbuf_wr_o, rb;
   int bad_count, num_checks;
   mpcs_row_t rows [7];
   mpcs_top dut (.*);
   mpcs_streamer_model model (.clk_i(clk_i), .rst_i(rst_i), .play_i(play), .bad_i(bad),
      .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .done_o(done));
   // Clock and thread capture; pulses last one cycle so keep the last one
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      if (thread_valid_o === 1'b1)
      begin
         th <= thread_o;
         rb <= rbuf_wr_o;
      end
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One classic cycle; ack and read data are taken at the same edge
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      if (wb_ack_o !== 1'b1)
         check("bus timeout", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
      if (bad_count > 0 && n >= 20)
         report_and_stop();
   endtask
   task automatic run_seq(input logic b);
      int n;
      n = 0;
      bad <= b;
      play <= 1'b1;
      @(posedge clk_i);
      play <= 1'b0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (done !== 1'b1 && n < 40);
      @(posedge clk_i);
      if (done !== 1'b1)
      begin
         check("model timeout", 32'h1, 32'h0);
         report_and_stop();
      end
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, child_req_i, msg_valid_i, msg_term_i, play, bad} = 8'h00;
      {wb_adr_i, msg_sfid_i, wb_dat_i} = 48'h0;
      wb_sel_i = 4'hF;
      child_hdl_a_i = 16'h0011;
      child_hdl_b_i = 16'h0022;
      bad_count = 0;
      num_checks = 0;
      rows = '{'{MPCS_A_CTRL, MPCS_CTRL_RST, "ctrl"},
         '{MPCS_A_STATUS, {29'h0, MPCS_ST_PRIM}, "status"},
         '{MPCS_A_OBJ_BASE, 32'h0000_1000, "obj base"},
         '{MPCS_A_OBJ_BOUND, 32'h0000_2000, "obj bound"},
         '{MPCS_A_ERR_CNT, 32'h0, "err count"},
         '{MPCS_A_TERM_CNT, 32'h0000_0002, "term count"},
         '{8'h18, 32'h0, "unmapped"}};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // Messages to the spawner and to another unit, then a legal setup
      for (int i = 0; i < 3; i++)
      begin
         msg_valid_i <= 1'b1;
         msg_term_i <= 1'b1;
         msg_sfid_i <= (i == 1) ? 8'h03 : MPCS_SPAWNER_SFID;
         @(posedge clk_i);
      end
      msg_valid_i <= 1'b0;
      msg_term_i <= 1'b0;
      run_seq(1'b0);
      check("ret handle", 32'h0, {16'h0, th.ret_handle});
      check("rbuf handle", 32'h0, {16'h0, rb.handle});
      check("rbuf data", 32'h5A5A_0001, rb.data);
      check("const handle", 32'h0001_00C3, {15'h0, th.const_en, th.const_handle});
      check("const slot", {30'h0, MPCS_SLOT_AFTER_HDR}, {30'h0, th.const_slot});
      check("fetch", 32'h0000_1100, obj_fetch_addr_o);
      check("fetch ok err", 32'h2, {30'h0, obj_fetch_ok_o, seq_err_o});
      $display("legal sequence test done");
      foreach (rows[i])
      begin
         wb(1'b0, rows[i].a, 32'h0);
         check(rows[i].n, rows[i].e, rd);
      end
      $display("register table test done");
      child_req_i <= 1'b1;
      @(posedge clk_i);
      child_req_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("child", 32'h1, {31'h0, th.child});
      check("child hdls", 32'h0011_0022, {th.ret_handle, th.tail_handle});
      $display("child thread test done");
      run_seq(1'b1);
      check("err flag", 32'h1, {31'h0, seq_err_o});
      check("next handle", {16'h0, MPCS_HDL_STEP}, {16'h0, rb.handle});
      wb(1'b0, MPCS_A_ERR_CNT, 32'h0);
      check("err count", 32'h1, rd);
      $display("late state test done");
      wb(1'b1, MPCS_A_OBJ_BASE, 32'hFFFF_FFFF);
      wb(1'b0, MPCS_A_OBJ_BASE, 32'h0);
      check("ro base", 32'h0000_1000, rd);
      wb(1'b1, MPCS_A_CTRL, 32'h0000_0003);
      wb(1'b0, MPCS_A_STATUS, 32'h0);
      check("status clr", {29'h0, MPCS_ST_PRIM}, rd);
      check("err clr", 32'h0, {31'h0, seq_err_o});
      $display("register write test done");
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, MPCS_A_CTRL, 32'h0);
      check("ctrl rst", MPCS_CTRL_RST, rd);
      wb(1'b0, MPCS_A_TERM_CNT, 32'h0);
      check("term rst", 32'h0, rd);
      wb(1'b0, MPCS_A_STATUS, 32'h0);
      check("status rst", 32'h0, rd);
      $display("reset test done");
      report_and_stop();
   end
endmodule
